// ### design/tbf_cfg.svh
// Timing, framing and protocol-control constants of the Type B block framer
`ifndef TBF_CFG_SVH
`define TBF_CFG_SVH
`define TBF_CLK_KHZ    50000
`define TBF_SUBC_KHZ   848
`define TBF_SUBC_HALF  (`TBF_CLK_KHZ / (2 * `TBF_SUBC_KHZ))
`define TBF_FRAME_MAX  256
`define TBF_BLK_OVH    3
`define TBF_CHAR_BITS  4'ha
`define TBF_SOF_ZEROS  4'ha
`define TBF_SOF_BITS   4'hc
`define TBF_SOF_PAT    12'hc00
`define TBF_EOF_BITS   4'ha
`define TBF_CRC_INIT   16'hffff
`define TBF_CRC_POLY   16'h8408
`define TBF_CRC_GOOD   16'hf0b8
`define TBF_PCB_I      8'h02
`define TBF_PCB_I_MSK  8'he2
`define TBF_PCB_R      8'ha2
`define TBF_PCB_R_MSK  8'he6
`define TBF_PCB_NAK    8'h10
`define TBF_PCB_SDES   8'hc2
`define TBF_PCB_S_MSK  8'hf7
`endif

// ### design/tbf_pkg.sv
// Types shared by the Type B block framer
package tbf_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RX   = 3'b010,
    ST_TX   = 3'b100
  } tbf_state_e;

  typedef enum logic [6:0] {
    TX_SOF  = 7'h01,
    TX_PCB  = 7'h02,
    TX_DAT  = 7'h04,
    TX_CRC0 = 7'h08,
    TX_CRC1 = 7'h10,
    TX_EOF  = 7'h20,
    TX_END  = 7'h40
  } tbf_step_e;

  typedef struct packed {
    tbf_state_e  state;
    tbf_step_e   step;
    logic        lclk_m;
    logic        lclk_s;
    logic        lclk_p;
    logic        rx_m;
    logic        rx_s;
    logic [3:0]  zc;
    logic [3:0]  bc;
    logic [7:0]  sh;
    logic [11:0] tsh;
    logic [8:0]  len;
    logic        ovf;
    logic [15:0] crc;
    logic [7:0]  pcb;
    logic [7:0]  tpcb;
    logic        tx_inf;
    logic        bn;
    logic        cmd_valid;
    logic [8:0]  cmd_len;
    logic        desel;
    logic [8:0]  tcnt;
    logic [7:0]  hold;
    logic        hold_full;
    logic        hold_last;
    logic        rsp_ready;
    logic        tx_on;
    logic        tx_bit;
    logic        lm;
    logic [5:0]  subc_cnt;
    logic        subc;
    logic        mem_we;
    logic [7:0]  mem_wa;
    logic [7:0]  mem_wd;
  } tbf_main_s;
endpackage

// ### design/tbf_mem_if.sv
// Write and read channel between the framer and its frame buffer
`timescale 1ns/1ns
interface tbf_mem_if #(parameter int AW = 8, parameter int DW = 8);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### design/tbf_mem.sv
// Frame buffer holding one received block, registered read port
`timescale 1ns/1ns
module tbf_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  tbf_mem_if.mem    m
);
  if (AW < 1 || AW > 16 || DW < 1) begin : g_chk
    $error("memory address or data width out of range");
  end

  logic [DW-1:0] ram [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (m.we) begin
      ram[m.waddr] <= m.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m.rdata <= '0;
    end else begin
      m.rdata <= ram[m.raddr];
    end
  end
endmodule

// ### design/tbf_framer.sv
// Type B tag-side frame and block handler
// Overview of operation
// - Each character is a low start bit, eight data bits least significant first, a high stop bit.
// - Replies leave as load modulation, the bit steering the phase of an 848 kHz subcarrier.
// - A frame is a start delimiter, the data field, then an end delimiter that closes it.
// - The data field is at most 256 bytes both ways; longer receptions are refused.
// - A block is one PCB byte, n payload bytes and a two-byte CRC_B.
// - The PCB names an information, receive-ready or supervisory block.
// - A receive-ready block carries only ack or nak and no payload.
// - A receive-ready reply carries the block number in force, not that of the block just received.
// - Only the deselect supervisory block is answered; wait extension is neither sent nor honoured.
// - The block number becomes 1 on every activation.
// - An information block received toggles the block number before the reply.
`timescale 1ns/1ns
`include "tbf_cfg.svh"
module tbf_framer
  import tbf_pkg::*;
#(
  parameter int unsigned FRAME_MAX = `TBF_FRAME_MAX
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       lnk_clk,
  input  wire logic       lnk_rx,
  input  wire logic       activate,
  output logic            lnk_tx,
  output logic            lnk_mod,
  output logic            tx_busy,
  output logic            block_num,
  output logic            cmd_valid,
  output logic [8:0]      cmd_len,
  input  wire logic [7:0] buf_raddr,
  output logic [7:0]      buf_rdata,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  input  wire logic       rsp_last,
  output logic            rsp_ready,
  output logic            deselect
);
  if (FRAME_MAX < `TBF_BLK_OVH || FRAME_MAX > 256) begin : g_chk
    $error("FRAME_MAX must lie between 3 and 256");
  end
  localparam logic [8:0] LEN_MAX = 9'(FRAME_MAX);
  localparam logic [8:0] INF_MAX = 9'(FRAME_MAX - `TBF_BLK_OVH);
  localparam logic [5:0] SUBC_END = 6'(`TBF_SUBC_HALF - 1);
  // ---------------------------------------------------------------
  // Reset release and frame buffer
  // ---------------------------------------------------------------
  logic [1:0] rs_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q <= 2'b00;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  tbf_mem_if #(.AW(8), .DW(8)) mif ();
  tbf_mem #(.AW(8), .DW(8)) u_mem (.clk(clk), .rst_n(rs_q[1]), .m(mif.mem));
  tbf_main_s q;
  tbf_main_s d;
  assign mif.we    = q.mem_we;
  assign mif.waddr = q.mem_wa;
  assign mif.wdata = q.mem_wd;
  assign mif.raddr = buf_raddr;
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `TBF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic tick;
  logic rxb;
  logic ok;
  always_comb begin
    d           = q;
    d.cmd_valid = 1'b0;
    d.desel     = 1'b0;
    d.mem_we    = 1'b0;
    // Link clock and data pass two flops before any logic looks at them
    d.lclk_m    = lnk_clk;
    d.lclk_s    = q.lclk_m;
    d.lclk_p    = q.lclk_s;
    d.rx_m      = lnk_rx;
    d.rx_s      = q.rx_m;
    tick        = q.lclk_s & ~q.lclk_p;
    rxb         = q.rx_s;
    ok          = 1'b0;
    // subcarrier phase keyed by the bit
    d.subc_cnt = (q.subc_cnt == SUBC_END) ? 6'h00 : q.subc_cnt + 6'h01;
    d.subc     = (q.subc_cnt == SUBC_END) ? ~q.subc : q.subc;
    d.lm = q.tx_on & (q.subc ^ q.tx_bit);
    if (rsp_valid && q.rsp_ready) begin
      d.hold      = rsp_data;
      d.hold_full = 1'b1;
      d.hold_last = rsp_last;
    end
    case (q.state)
      ST_IDLE: begin
        // start delimiter is ten or more lows then a high
        if (tick) begin
          if (!rxb) begin
            d.zc = (q.zc == `TBF_SOF_ZEROS) ? q.zc : q.zc + 4'h1;
          end else begin
            d.zc = 4'h0;
            if (q.zc == `TBF_SOF_ZEROS) begin
              d.state = ST_RX;
              d.bc    = 4'h0;
              d.len   = 9'h000;
              d.ovf   = 1'b0;
              d.crc   = `TBF_CRC_INIT;
            end
          end
        end
      end
      ST_RX: begin
        if (tick) begin
          // start bit, LSB-first data, stop bit
          if (q.bc == 4'h0) begin
            if (!rxb) d.bc = 4'h1;
          end else if (q.bc < 4'h9) begin
            d.sh = {rxb, q.sh[7:1]};
            d.bc = q.bc + 4'h1;
          end else if (rxb) begin
            d.bc = 4'h0;
            // bytes past the limit are dropped and spoil the frame
            if (q.len < LEN_MAX) begin
              d.mem_we = 1'b1;
              d.mem_wa = q.len[7:0];
              d.mem_wd = q.sh;
              d.crc    = crc_upd(q.crc, q.sh);
              d.len    = q.len + 9'h001;
              if (q.len == 9'h000) d.pcb = q.sh;
            end else begin
              d.ovf = 1'b1;
            end
          end else begin
            // an all-low character is the end delimiter
            d.bc       = 4'h0;
            d.state    = ST_TX;
            d.step     = TX_SOF;
            d.tx_on    = 1'b1;
            d.tx_inf   = 1'b0;
            d.tcnt     = 9'h000;
            // least legal block with a passing check
            ok = (q.sh == 8'h00) && !q.ovf && (q.len >= 9'(`TBF_BLK_OVH))
                 && (q.crc == `TBF_CRC_GOOD);
            if (!ok) begin
              // nak names the block number in force
              d.tpcb = `TBF_PCB_R | `TBF_PCB_NAK | {7'h00, q.bn};
            end else if ((q.pcb & `TBF_PCB_I_MSK) == `TBF_PCB_I) begin
              // toggle before the reply goes out
              d.bn        = ~q.bn;
              d.tpcb      = `TBF_PCB_I | {7'h00, ~q.bn};
              d.tx_inf    = 1'b1;
              d.cmd_valid = 1'b1;
              d.cmd_len   = q.len - 9'(`TBF_BLK_OVH);
            end else if ((q.pcb & `TBF_PCB_R_MSK) == `TBF_PCB_R) begin
              d.tpcb = `TBF_PCB_R | {7'h00, q.bn};
            end else if ((q.pcb & `TBF_PCB_S_MSK) == `TBF_PCB_SDES) begin
              d.tpcb  = `TBF_PCB_SDES;
              d.desel = 1'b1;
            end else begin
              // wait extension and unknown codes get no answer
              d.state = ST_IDLE;
              d.tx_on = 1'b0;
            end
          end
        end
      end
      ST_TX: begin
        if (tick && q.bc != 4'h0) begin
          d.tx_bit = q.tsh[0];
          d.tsh    = {1'b1, q.tsh[11:1]};
          d.bc     = q.bc - 4'h1;
        end else if (!tick && q.bc == 4'h0 && (q.step != TX_END || !q.lclk_s)) begin
          case (q.step)
            TX_SOF: begin
              d.tsh  = `TBF_SOF_PAT;
              d.bc   = `TBF_SOF_BITS;
              d.crc  = `TBF_CRC_INIT;
              d.step = TX_PCB;
            end
            TX_PCB: begin
              d.tsh  = {3'b111, q.tpcb, 1'b0};
              d.bc   = `TBF_CHAR_BITS;
              d.crc  = crc_upd(q.crc, q.tpcb);
              d.step = q.tx_inf ? TX_DAT : TX_CRC0;
            end
            TX_DAT: begin
              // the reply is cut at the size limit
              if (q.tcnt == INF_MAX) begin
                d.step = TX_CRC0;
              end else if (q.hold_full) begin
                d.tsh       = {3'b111, q.hold, 1'b0};
                d.bc        = `TBF_CHAR_BITS;
                d.crc       = crc_upd(q.crc, q.hold);
                d.hold_full = 1'b0;
                d.tcnt      = q.tcnt + 9'h001;
                if (q.hold_last) d.step = TX_CRC0;
              end
            end
            TX_CRC0: begin
              d.tsh  = {3'b111, ~q.crc[7:0], 1'b0};
              d.bc   = `TBF_CHAR_BITS;
              d.step = TX_CRC1;
            end
            TX_CRC1: begin
              d.tsh  = {3'b111, ~q.crc[15:8], 1'b0};
              d.bc   = `TBF_CHAR_BITS;
              d.step = TX_EOF;
            end
            TX_EOF: begin
              d.tsh  = 12'h000;
              d.bc   = `TBF_EOF_BITS;
              d.step = TX_END;
            end
            default: begin
              // Idle only once the link clock is low: the last EOF bit has been sampled
              d.state  = ST_IDLE;
              d.tx_on  = 1'b0;
              d.tx_bit = 1'b1;
              d.zc     = 4'h0;
            end
          endcase
        end
      end
      default: d.state = ST_IDLE;
    endcase
    // activation restarts the block number at 1
    if (activate) d.bn = 1'b1;
    // Underrun idles the line high between characters, so the source may stall
    d.rsp_ready = (d.state == ST_TX) && d.tx_inf && (d.step == TX_DAT) && !d.hold_full;
  end
  always_ff @(posedge clk or negedge rs_q[1]) begin
    if (!rs_q[1]) begin
      q        <= '0;
      q.state  <= ST_IDLE;
      q.step   <= TX_SOF;
      q.tx_bit <= 1'b1;
      q.bn     <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign lnk_tx    = q.tx_bit;
  assign lnk_mod   = q.lm;
  assign tx_busy   = q.tx_on;
  assign block_num = q.bn;
  assign cmd_valid = q.cmd_valid;
  assign cmd_len   = q.cmd_len;
  assign buf_rdata = mif.rdata;
  assign rsp_ready = q.rsp_ready;
  assign deselect  = q.desel;
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rs_q[1]);
  a_char_frame: assert property (
    (q.state == ST_TX && q.bc == `TBF_CHAR_BITS && q.step != TX_END)
      |-> (q.tsh[0] == 1'b0 && q.tsh[9] == 1'b1))
    else $error("character lacks start or stop bit");
  a_mod_quiet: assert property (!q.tx_on |=> !q.lm)
    else $error("modulation outside a reply");
  a_mod_phase: assert property (q.tx_on |=> (q.lm == ($past(q.subc) ^ $past(q.tx_bit))))
    else $error("subcarrier phase not keyed by bit");
  a_reply_sof: assert property (
    $rose(q.state == ST_TX) |-> (q.step == TX_SOF && q.bc == 4'h0))
    else $error("reply does not open with start delimiter");
  a_rx_size: assert property (q.len <= LEN_MAX && q.tcnt <= INF_MAX)
    else $error("data field over size limit");
  a_rblk_noinf: assert property ((q.state == ST_TX && !q.tx_inf) |-> !q.rsp_ready)
    else $error("payload requested for non-information reply");
  a_desel_pcb: assert property (q.desel |-> (q.tpcb == `TBF_PCB_SDES && q.state == ST_TX))
    else $error("deselect not answered in kind");
  a_bn_activate: assert property (activate |=> q.bn)
    else $error("activation did not set block number");
  a_bn_toggle: assert property (
    q.cmd_valid |-> (q.bn != $past(q.bn) && q.tpcb[0] == q.bn))
    else $error("block number not toggled for reply");
  a_crc_gate: assert property (q.cmd_valid |-> (q.crc == `TBF_CRC_GOOD))
    else $error("payload passed on with bad check value");
  c_iblock: cover property (q.cmd_valid ##[1:1000] $fell(q.tx_on));
  c_desel:  cover property (q.desel);
  c_nak:    cover property ($rose(q.state == ST_TX) && q.tpcb[4]);
endmodule

// ### testbench/tbf_reader_model.sv
// Reader-side model: sends command frames and decodes the tag's reply frame
`timescale 1ns/1ns
`include "tbf_cfg.svh"
module tbf_reader_model (
  output logic      lnk_clk,
  output logic      lnk_rx,
  input  wire logic lnk_tx
);
  logic [7:0] rx_q[$];
  logic       rx_done;
  int         sof_zeros;
  int         stop_errs;
  int         nbits;

  initial begin
    lnk_clk = 1'b0;
    lnk_rx  = 1'b1;
  end

  function automatic logic [15:0] crc_b(input logic [7:0] d[$]);
    logic [15:0] c;
    c = `TBF_CRC_INIT;
    foreach (d[i]) begin
      c = c ^ {8'h00, d[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ `TBF_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Link clock only runs while a bit moves; the reply level is settled by the fall
  task automatic bit_io(input logic b, output logic r);
    lnk_rx = b;
    #80 lnk_clk = 1'b1;
    #80 lnk_clk = 1'b0;
    r = lnk_tx;
    nbits++;
  endtask

  // delimiters, PCB then payload without identifier bytes, CRC_B
  task automatic send(input logic [7:0] d[$], input logic bad);
    logic [15:0] c;
    logic        r;
    c = ~crc_b(d) ^ {15'h0000, bad};
    d.push_back(c[7:0]);
    d.push_back(c[15:8]);
    repeat (10) bit_io(1'b0, r);
    bit_io(1'b1, r);
    foreach (d[i]) begin
      bit_io(1'b0, r);
      for (int k = 0; k < 8; k++) bit_io(d[i][k], r);
      bit_io(1'b1, r);
    end
    repeat (10) bit_io(1'b0, r);
  endtask

  // Our line is released during the reply, so it toggles rather than holding a level
  task automatic recv(input int lim);
    logic       r;
    logic [7:0] b;
    rx_q      = {};
    rx_done   = 1'b0;
    sof_zeros = 0;
    stop_errs = 0;
    nbits     = 0;
    r         = 1'b1;
    while (r && nbits < lim) bit_io(~lnk_rx, r);
    while (!r && nbits < lim) begin
      sof_zeros++;
      bit_io(~lnk_rx, r);
    end
    while (!rx_done && nbits < lim) begin
      bit_io(~lnk_rx, r);
      if (!r) begin
        for (int k = 0; k < 8; k++) bit_io(~lnk_rx, b[k]);
        bit_io(~lnk_rx, r);
        if (b == 8'h00 && !r) begin
          rx_done = 1'b1;
        end else begin
          if (!r) stop_errs++;
          rx_q.push_back(b);
        end
      end
    end
  endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the Type B block framer
`timescale 1ns/1ns
module tb_top;
  logic       clk;
  logic       rst_n;
  logic       lnk_clk;
  logic       lnk_rx;
  logic       lnk_tx;
  logic       lnk_mod;
  logic       tx_busy;
  logic       block_num;
  logic       cmd_valid;
  logic [8:0] cmd_len;
  logic       activate;
  logic [7:0] buf_raddr;
  logic [7:0] buf_rdata;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_last;
  logic       rsp_ready;
  logic       deselect;
  logic       busy_p = 1'b0;
  logic       mod_p  = 1'b0;
  int         fail_count = 0;
  int         num_checks = 0;
  int         n_cmd  = 0;
  int         n_des  = 0;
  int         n_busy = 0;
  int         n_mod  = 0;
  int         n_idle = 0;

  tbf_framer tbf_framer_inst (
    .clk(clk), .rst_n(rst_n), .lnk_clk(lnk_clk), .lnk_rx(lnk_rx), .activate(activate),
    .lnk_tx(lnk_tx), .lnk_mod(lnk_mod), .tx_busy(tx_busy), .block_num(block_num),
    .cmd_valid(cmd_valid), .cmd_len(cmd_len), .buf_raddr(buf_raddr), .buf_rdata(buf_rdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
    .deselect(deselect));
  tbf_reader_model tbf_reader_model_inst (.lnk_clk(lnk_clk), .lnk_rx(lnk_rx), .lnk_tx(lnk_tx));

  always #10 clk = ~clk;

  // Event counters; modulation must stay quiet while no reply is on the air
  always @(posedge clk) begin
    busy_p <= tx_busy;
    mod_p  <= lnk_mod;
    if (cmd_valid === 1'b1) n_cmd++;
    if (deselect === 1'b1) n_des++;
    if (tx_busy === 1'b1 && busy_p === 1'b0) n_busy++;
    if (tx_busy === 1'b1 && lnk_mod !== mod_p) n_mod++;
    if (tx_busy === 1'b0 && busy_p === 1'b0 && lnk_mod !== 1'b0) n_idle++;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic feed(input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      rsp_valid = 1'b1;
      rsp_data  = 8'h5a + 8'(i);
      rsp_last  = (i == n - 1);
      w = 0;
      // A full-size command frame alone lasts over 20000 cycles
      while (rsp_ready !== 1'b1 && w < 40000) begin
        @(posedge clk);
        #1;
        w++;
      end
      if (w >= 40000) fail_count++;
    end
    @(posedge clk);
    #1;
    rsp_valid = 1'b0;
    rsp_last  = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] pcb, input int n, input logic bad, input int nrsp);
    logic [7:0] d[$];
    d = {pcb};
    for (int i = 0; i < n; i++) d.push_back(8'h11 + 8'(i));
    fork
      begin
        tbf_reader_model_inst.send(d, bad);
        tbf_reader_model_inst.recv(40 * nrsp + 200);
      end
      feed(nrsp);
    join
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic check_reply(input logic [7:0] e[$]);
    logic [15:0] c;
    c = ~tbf_reader_model_inst.crc_b(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    check(16'(tbf_reader_model_inst.rx_done), 16'h0001);
    check(16'(tbf_reader_model_inst.sof_zeros), 16'h000a);
    check(16'(tbf_reader_model_inst.stop_errs), 16'h0000);
    check(16'(tbf_reader_model_inst.rx_q.size()), 16'(e.size()));
    foreach (e[i]) check({8'h00, tbf_reader_model_inst.rx_q[i]}, {8'h00, e[i]});
  endtask

  task automatic rd_buf(input logic [7:0] a, input logic [7:0] exp);
    buf_raddr = a;
    @(posedge clk);
    #1;
    check({8'h00, buf_rdata}, {8'h00, exp});
  endtask

  task automatic t_reset;
    check(16'(lnk_tx), 16'h0001);
    check(16'(block_num), 16'h0001);
    check(16'(tx_busy), 16'h0000);
    check(16'(lnk_mod), 16'h0000);
  endtask

  task automatic t_info(input logic [7:0] pcb, input int n, input logic bn);
    int c0;
    c0 = n_cmd;
    xfer(pcb, n, 1'b0, 2);
    check(16'(n_cmd), 16'(c0 + 1));
    check(16'(cmd_len), 16'(n));
    check(16'(block_num), 16'(bn));
    rd_buf(8'h00, pcb);
    rd_buf(8'h01, 8'h11);
    rd_buf(8'(n), 8'h11 + 8'(n - 1));
    check_reply({8'h02 | {7'h00, bn}, 8'h5a, 8'h5b});
  endtask

  // Frame that must never reach the user: no command strobe, block number kept
  task automatic ctl(input logic [7:0] pcb, input int n, input logic bad);
    int   c0;
    logic bn;
    c0 = n_cmd;
    bn = block_num;
    xfer(pcb, n, bad, 0);
    check(16'(n_cmd), 16'(c0));
    check(16'(block_num), 16'(bn));
  endtask

  task automatic t_badcrc;
    ctl(8'h02, 3, 1'b1);
    check_reply({8'hb2 | {7'h00, block_num}});
  endtask

  task automatic t_rack;
    ctl(8'ha3, 0, 1'b0);
    check_reply({8'ha2 | {7'h00, block_num}});
  endtask

  task automatic t_wtx;
    int b0;
    b0 = n_busy;
    ctl(8'hf2, 1, 1'b0);
    check(16'(n_busy - b0), 16'h0000);
  endtask

  task automatic t_desel;
    int d0;
    d0 = n_des;
    ctl(8'hc2, 0, 1'b0);
    check(16'(n_des - d0), 16'h0001);
    check_reply({8'hc2});
  endtask

  task automatic t_activate;
    @(posedge clk);
    #1;
    activate = 1'b1;
    @(posedge clk);
    #1;
    activate = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(16'(block_num), 16'h0001);
  endtask

  task automatic t_size;
    t_info(8'h02, 253, 1'b1);
    ctl(8'h02, 254, 1'b0);
    check_reply({8'hb2 | {7'h00, block_num}});
  endtask

  initial begin
    clk       = 1'b0;
    rst_n     = 1'b0;
    activate  = 1'b0;
    buf_raddr = 8'h00;
    rsp_valid = 1'b0;
    rsp_data  = 8'h00;
    rsp_last  = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset;
    t_info(8'h02, 2, 1'b0);
    t_activate;
    t_info(8'h03, 1, 1'b0);
    t_badcrc;
    t_rack;
    t_wtx;
    t_desel;
    t_size;
    check(16'(n_mod > 0), 16'h0001);
    check(16'(n_idle), 16'h0000);
    end_sim;
  end

  initial begin
    #1500000;
    fail_count++;
    end_sim;
  end
endmodule
